//--- verification/oodt_chk_monitor.sv
// Purpose: concurrent checks on the ports of the timer pair
// Assumes: TICK_CYCLES of 4 and ce_i held high by the bench
// Notes:   bound to every oodt_top instance at the foot of this file
`default_nettype none

module oodt_chk #(
   parameter int unsigned TICK_CYCLES = 4
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // register bus
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] adr_i,
   input  wire logic [31:0] dat_o,
   input  wire logic        ack_o,
   // timers
   input  wire logic        on_trg_i,
   input  wire logic        off_trg_i,
   input  wire logic        off_clr_i,
   input  wire logic        pwr_restore_i,
   input  wire logic        on_q_o,
   input  wire logic        off_q_o,
   input  wire logic [31:0] on_elapsed_o,
   input  wire logic [31:0] off_elapsed_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ------------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------------
   // request taken by the slave
   sequence s_req;
      cyc_i && stb_i && !ack_o && ce_i;
   endsequence
   // clear held across one full tick period of 4 cycles
   sequence s_clr_held;
      (off_clr_i && ce_i)[*4];
   endsequence

   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   property p_ack;
      s_req |=> ack_o ##1 !ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one pulse after request");

   property p_rd_el;
      s_req ##0 (!we_i && adr_i[7:0] == 8'h10) |=> dat_o == $past(on_elapsed_o);
   endproperty
   a_rd_el: assert property (p_rd_el) else $error("elapsed read differs");

   property p_on_step;
      (on_elapsed_o > $past(on_elapsed_o))
         |-> $past(on_trg_i) && (on_elapsed_o <= $past(on_elapsed_o) + 32'h0000000a);
   endproperty
   a_on_step: assert property (p_on_step) else $error("on elapsed step wrong");

   property p_on_rise;
      $rose(on_q_o) |-> $past(on_trg_i);
   endproperty
   a_on_rise: assert property (p_on_rise) else $error("on output rose with low trg");

   property p_off_rise;
      $rose(off_q_o) |-> $past(off_trg_i) && !$past(off_clr_i);
   endproperty
   a_off_rise: assert property (p_off_rise) else $error("off output rose wrongly");

   property p_off_fall;
      $fell(off_q_o) |-> !$past(off_trg_i) || $past(off_clr_i) || $past(pwr_restore_i);
   endproperty
   a_off_fall: assert property (p_off_fall) else $error("off output fell with trg");

   property p_off_step;
      (off_elapsed_o > $past(off_elapsed_o)) |-> !$past(off_trg_i) && $past(off_q_o);
   endproperty
   a_off_step: assert property (p_off_step) else $error("off elapsed ran wrongly");

   property p_clr;
      s_clr_held |=> !off_q_o && off_elapsed_o == 32'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("clear did not zero off timer");
endmodule

bind oodt_top oodt_chk #(.TICK_CYCLES(TICK_CYCLES)) u_oodt_chk (
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .on_trg_i(on_trg_i),
   .off_trg_i(off_trg_i), .off_clr_i(off_clr_i), .pwr_restore_i(pwr_restore_i),
   .on_q_o(on_q_o), .off_q_o(off_q_o), .on_elapsed_o(on_elapsed_o),
   .off_elapsed_o(off_elapsed_o)
);

`default_nettype wire

//--- verification/oodt_src_blk.sv
// Purpose: another block of the program whose actual value feeds a delay
// Assumes: value loaded by the bench one cycle at a time
// Notes:   signed, unclamped, so out-of-range values reach the timers
`default_nettype none

module oodt_src_blk (
   // clock and reset
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   // value load
   input  wire logic               ld_i,
   input  wire logic signed [31:0] val_i,
   // actual value
   output var  logic signed [31:0] act_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // actual value register, zero after reset
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         act_o <= 32'sh0;
      else if (ld_i)
         act_o <= val_i;
   end
endmodule

`default_nettype wire

//--- verification/testbench.sv
// Purpose: self-checking bench for the on/off delay timer pair
// Assumes: tick shortened to 4 cycles, ce_i and sel_i tied
// Notes:   tick phase learnt from the first off-delay output rise
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TCK = 4;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [31:0] adr_i = 32'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        on_trg_i = 1'b0;
   logic        off_trg_i = 1'b0;
   logic        off_clr_i = 1'b0;
   logic        pwr_restore_i = 1'b0;
   logic        ld = 1'b0;
   logic [31:0] val = 32'h0;
   logic [31:0] ext_val;
   logic        on_q_o;
   logic        off_q_o;
   logic [31:0] on_elapsed_o;
   logic [31:0] off_elapsed_o;
   int          cyc = 0;
   int          t0 = 0;
   int          n_mismatch = 0;
   int          n_tests = 0;

   // ------------------------------------------------------------------
   // design and partner
   // ------------------------------------------------------------------
   oodt_top #(.TICK_CYCLES(TCK)) u_oodt_top (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .on_trg_i(on_trg_i), .off_trg_i(off_trg_i), .off_clr_i(off_clr_i),
      .pwr_restore_i(pwr_restore_i), .on_ext_val_i(ext_val), .off_ext_val_i(ext_val),
      .on_q_o(on_q_o), .off_q_o(off_q_o), .on_elapsed_o(on_elapsed_o),
      .off_elapsed_o(off_elapsed_o)
   );
   oodt_src_blk u_oodt_src_blk (
      .clk_i(clk_i), .rst_i(rst_i), .ld_i(ld), .val_i(val), .act_o(ext_val)
   );

   // clock and cycle count
   initial
   begin
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) cyc <= cyc + 1;

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic end_of_test;
      if (n_mismatch == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {24'h0, a};
      dat_i <= wd;
      @(posedge clk_i iff ack_o);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      wb(1'b1, a, d, v);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      wb(1'b0, a, 32'h0, v);
      chk(nm, exp, v);
   endtask

   // wait to the edge just after the n-th timer tick
   task automatic tk(input int n);
      repeat (n) @(posedge clk_i iff ((cyc - t0) % TCK == 0));
   endtask

   // elapsed and output of one timer
   task automatic st(input logic off, input logic [31:0] el, input logic q);
      chk(off ? "off_elapsed" : "on_elapsed", el, off ? off_elapsed_o : on_elapsed_o);
      chk(off ? "off_q" : "on_q", {31'h0, q}, {31'h0, off ? off_q_o : on_q_o});
   endtask

   task automatic pulse_pwr;
      pwr_restore_i <= 1'b1;
      @(posedge clk_i);
      pwr_restore_i <= 1'b0;
   endtask

   // ------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------
   task automatic t_regs;
      rdc("ctrl", 8'h00, 32'h0);
      rdc("on_cfg", 8'h04, 32'h0);
      wr(8'h10, 32'h00001234);
      rdc("ro_elapsed", 8'h10, 32'h0);
      rdc("unmapped", 8'h20, 32'h0);
   endtask

   task automatic t_dly;
      logic [17:0] cf [9];
      logic [31:0] xv [9];
      logic [31:0] ex [9];
      cf = '{{2'h0, 2'h0, 7'h63, 7'h7f}, {2'h0, 2'h1, 7'h63, 7'h46},
             {2'h0, 2'h2, 7'h01, 7'h02}, {2'h1, 2'h0, 7'h00, 7'h00},
             {2'h1, 2'h0, 7'h00, 7'h00}, {2'h1, 2'h1, 7'h00, 7'h00},
             {2'h1, 2'h2, 7'h00, 7'h00}, {2'h2, 2'h0, 7'h00, 7'h00},
             {2'h0, 2'h0, 7'h00, 7'h03}};
      xv = '{32'h0, 32'h0, 32'h0, 32'h000186a0, 32'hfffffffb, 32'h00001b58, 32'h3, 32'h5,
             32'h0};
      ex = '{32'h00018696, 32'h005b8998, 32'h0038c340, 32'h00018696, 32'h0,
             32'h005b8998, 32'h0002bf20, 32'h0, 32'h0000001e};
      for (int i = 0; i < 9; i++)
      begin
         @(posedge clk_i);
         ld <= 1'b1;
         val <= xv[i];
         @(posedge clk_i);
         ld <= 1'b0;
         wr(8'h04, {14'h0, cf[i]});
         rdc("on_delay", 8'h18, ex[i]);
      end
      wr(8'h08, 32'h00000003);
      rdc("off_delay", 8'h1c, 32'h1e);
   endtask

   task automatic t_on;
      tk(1);
      on_trg_i <= 1'b1;
      tk(1);
      st(1'b0, 32'h0, 1'b0);
      tk(2);
      st(1'b0, 32'h14, 1'b0);
      tk(1);
      st(1'b0, 32'h1e, 1'b1);
      rdc("on_elapsed", 8'h10, 32'h1e);
      tk(1);
      on_trg_i <= 1'b0;
      tk(1);
      st(1'b0, 32'h0, 1'b0);
      on_trg_i <= 1'b1;
      tk(3);
      st(1'b0, 32'h14, 1'b0);
      on_trg_i <= 1'b0;
      tk(1);
      st(1'b0, 32'h0, 1'b0);
      on_trg_i <= 1'b1;
      tk(1);
      st(1'b0, 32'h0, 1'b0);
      tk(3);
      st(1'b0, 32'h1e, 1'b1);
   endtask

   task automatic t_pwr;
      pulse_pwr;
      tk(1);
      st(1'b0, 32'h0, 1'b0);
      tk(3);
      st(1'b0, 32'h1e, 1'b1);
      wr(8'h00, 32'h00000001);
      tk(1);
      pulse_pwr;
      tk(1);
      st(1'b0, 32'h1e, 1'b1);
      on_trg_i <= 1'b0;
   endtask

   task automatic t_off;
      tk(1);
      off_trg_i <= 1'b1;
      tk(1);
      st(1'b1, 32'h0, 1'b1);
      off_trg_i <= 1'b0;
      tk(1);
      st(1'b1, 32'h0, 1'b1);
      tk(2);
      st(1'b1, 32'h14, 1'b1);
      off_trg_i <= 1'b1;
      tk(1);
      off_trg_i <= 1'b0;
      tk(1);
      st(1'b1, 32'h0, 1'b1);
      tk(2);
      st(1'b1, 32'h14, 1'b1);
      tk(1);
      st(1'b1, 32'h1e, 1'b0);
      off_trg_i <= 1'b1;
      tk(1);
      off_trg_i <= 1'b0;
      tk(2);
      st(1'b1, 32'h0a, 1'b1);
      off_clr_i <= 1'b1;
      tk(1);
      st(1'b1, 32'h0, 1'b0);
      off_clr_i <= 1'b0;
   endtask

   // ------------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------------
   initial
   begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_dly;
      @(posedge clk_i);
      off_trg_i <= 1'b1;
      @(posedge clk_i iff off_q_o);
      t0 = cyc;
      off_trg_i <= 1'b0;
      t_on;
      t_pwr;
      t_off;
      end_of_test;
   end

   // cut a hang short well past the expected run length
   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      end_of_test;
   end
endmodule

`default_nettype wire

//--- verilog/oodt_delay_cv.sv
// Purpose: turns one delay setting into a delay in ms
// Assumes: setting and values stable over a cycle
// Notes:   result registered, one cycle behind its inputs
`default_nettype none
`include "oodt_params.svh"

module oodt_delay_cv (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   // setting and result
   oodt_dly_if.cvt   dly
);
   import oodt_pkg::*;

   typedef struct packed {
      logic [31:0] delay_ms;
   } oodt_cv_st_t;

   oodt_cv_st_t st_r;
   oodt_cv_st_t st_nxt;

   // limit a referenced value to 0..max
   function automatic logic [31:0] clamp(input logic signed [31:0] v,
                                         input logic        [31:0] max);
      if (v < 0)
         clamp = 32'h0;
      else if ($unsigned(v) > max)
         clamp = max;
      else
         clamp = $unsigned(v);
   endfunction

   // resolve constant or referenced setting
   always_comb
   begin
      logic [6:0]         mj;
      logic [6:0]         mn;
      logic [6:0]         mn_max;
      logic signed [31:0] raw;
      logic [31:0]        units;
      mj     = (dly.cfg.major > `OODT_MAJOR_MAX) ? `OODT_MAJOR_MAX : dly.cfg.major;
      mn_max = (dly.cfg.tb == OODT_TB_MID || dly.cfg.tb == OODT_TB_COARSE)
               ? `OODT_MINOR_SIX_MAX : `OODT_MINOR_SEC_MAX;
      mn     = (dly.cfg.minor > mn_max) ? mn_max : dly.cfg.minor;
      raw    = (dly.cfg.src == OODT_SRC_PEER) ? $signed(dly.peer_val) : dly.ext_val;
      units  = 32'(mj) * `OODT_UNITS_PER_NEXT + 32'(mn);
      st_nxt = st_r;
      if (dly.cfg.src == OODT_SRC_EXT || dly.cfg.src == OODT_SRC_PEER)
      begin
         case (dly.cfg.tb)
            OODT_TB_MID:    st_nxt.delay_ms = clamp(raw, `OODT_REF_UNIT_MAX) * `OODT_MS_PER_SEC;
            OODT_TB_COARSE: st_nxt.delay_ms = clamp(raw, `OODT_REF_UNIT_MAX) * `OODT_MS_PER_MIN;
            default:        st_nxt.delay_ms = clamp(raw, `OODT_REF_MS_MAX);
         endcase
      end
      else
      begin
         case (dly.cfg.tb)
            OODT_TB_MID:    st_nxt.delay_ms = units * `OODT_MS_PER_SEC;
            OODT_TB_COARSE: st_nxt.delay_ms = units * `OODT_MS_PER_MIN;
            default:        st_nxt.delay_ms = 32'(mj) * `OODT_MS_PER_SEC
                                              + 32'(mn) * `OODT_MS_PER_TICK;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_r <= '0;
      else if (ce_i)
         st_r <= st_nxt;
   end

   assign dly.delay_ms = st_r.delay_ms;
endmodule

`default_nettype wire

//--- verilog/oodt_dly_if.sv
// Purpose: carries one timer's delay setting to its resolver
// Assumes: oodt_pkg compiled first
// Notes:   owner drives setting and candidate values, resolver the delay
`default_nettype none

interface oodt_dly_if;
   oodt_pkg::oodt_cfg_t cfg;
   logic signed [31:0]  ext_val;
   logic        [31:0]  peer_val;
   logic        [31:0]  delay_ms;

   modport owner (output cfg, output ext_val, output peer_val, input delay_ms);
   modport cvt   (input cfg, input ext_val, input peer_val, output delay_ms);
endinterface

`default_nettype wire

//--- verilog/oodt_params.svh
// Purpose: constants of the on/off delay timer pair
// Assumes: included by bare name wherever offsets or counts are needed
// Notes:   times held in ms, evaluation tick every 10 ms
`ifndef OODT_PARAMS_SVH
`define OODT_PARAMS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define OODT_CLK_PERIOD_NS   10
`define OODT_TICK_PERIOD_MS  10
`define OODT_TICK_CYCLES     ((`OODT_TICK_PERIOD_MS * 1000000) / `OODT_CLK_PERIOD_NS)
`define OODT_MS_PER_TICK     32'd10
`define OODT_MS_PER_SEC      32'd1000
`define OODT_MS_PER_MIN      32'd60000
`define OODT_UNITS_PER_NEXT  32'd60

// ----------------------------------------------------------------------
// constant delay limits (major:minor)
// ----------------------------------------------------------------------
`define OODT_MAJOR_MAX       7'd99
`define OODT_MINOR_SEC_MAX   7'd99
`define OODT_MINOR_SIX_MAX   7'd59

// ----------------------------------------------------------------------
// referenced delay limits
// ----------------------------------------------------------------------
`define OODT_REF_MS_MAX      32'd99990
`define OODT_REF_UNIT_MAX    32'd5999

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OODT_OFF_CTRL        8'h00
`define OODT_OFF_ON_CFG      8'h04
`define OODT_OFF_OFF_CFG     8'h08
`define OODT_OFF_STATUS      8'h0c
`define OODT_OFF_ON_ELAPSED  8'h10
`define OODT_OFF_OFF_ELAPSED 8'h14
`define OODT_OFF_ON_DELAY    8'h18
`define OODT_OFF_OFF_DELAY   8'h1c

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define OODT_CTRL_ON_KEEP    0
`define OODT_CTRL_OFF_KEEP   1
`define OODT_STAT_ON_Q       0
`define OODT_STAT_OFF_Q      1
`define OODT_STAT_ON_TRG     2
`define OODT_STAT_OFF_TRG    3
`define OODT_CFG_WIDTH       18
`define OODT_CTRL_RST        2'h0
`define OODT_CFG_RST         18'h00000

`endif

//--- verilog/oodt_pkg.sv
// Purpose: types shared by the delay timer pair
// Assumes: nothing beyond the params header
// Notes:   cfg word layout is src[17:16] tb[15:14] major[13:7] minor[6:0]
`default_nettype none

package oodt_pkg;

   // delay source, also the block number of the value feeding it
   typedef enum logic [1:0] {
      OODT_SRC_CONST,
      OODT_SRC_EXT,
      OODT_SRC_PEER
   } oodt_src_t;

   // timebase: const s/m/h, referenced ms/s/min
   typedef enum logic [1:0] {
      OODT_TB_FINE,
      OODT_TB_MID,
      OODT_TB_COARSE
   } oodt_tb_t;

   typedef struct packed {
      oodt_src_t  src;
      oodt_tb_t   tb;
      logic [6:0] major;
      logic [6:0] minor;
   } oodt_cfg_t;

endpackage

`default_nettype wire

//--- verilog/oodt_tick.sv
// Purpose: evaluation time base, one pulse per tick period
// Assumes: ce_i low freezes the count
// Notes:   CYCLES may be shortened for simulation
`default_nettype none
`include "oodt_params.svh"

module oodt_tick #(
   parameter int unsigned CYCLES = `OODT_TICK_CYCLES
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   // tick
   output var  logic tick_o
);
   import oodt_pkg::*;

   typedef struct packed {
      logic [31:0] cnt;
      logic        tick;
   } oodt_tick_st_t;

   oodt_tick_st_t st_r;
   oodt_tick_st_t st_nxt;

   // count up through the period, pulse at wrap
   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.tick = 1'b0;
      if (st_r.cnt >= 32'(CYCLES - 1))
      begin
         st_nxt.cnt  = 32'h0;
         st_nxt.tick = 1'b1;
      end
      else
      begin
         st_nxt.cnt = st_r.cnt + 32'h1;
      end
   end

   // state register
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_r <= '0;
      else if (ce_i)
         st_r <= st_nxt;
   end

   assign tick_o = st_r.tick;
endmodule

`default_nettype wire

//--- verilog/oodt_top.sv
// Purpose: on-delay and off-delay timer pair with a Wishbone register file
// Assumes: inputs synchronous to clk_i, classic Wishbone master
// Notes:   timers evaluate once per tick; all state frozen while ce_i low
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`default_nettype none
`include "oodt_params.svh"

// Overview of operation
// - on-delay rising trigger restarts elapsed at zero
// - on-delay output set when elapsed reaches delay
// - early trigger fall clears elapsed, no output
// - on-delay output low whenever trigger low
// - restore keeps state if kept, else defaults
// - constant delay limits 99:99 s, 99:59 m/h
// - referenced delay read as ms, s or min
// - referenced value clamped into valid range
// - delay source constant or another block's value
// - off-delay output rises at once with trigger
// - falling trigger restarts elapsed, output stays high
// - off-delay output clears when elapsed equals delay
// - new trigger pulse restarts the off-delay
// - clear input zeroes elapsed and off output
// - elapsed times exposed for others to use
module oodt_top #(
   parameter int unsigned TICK_CYCLES = `OODT_TICK_CYCLES
) (
   // clock, reset, enable
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [31:0] adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output var  logic [31:0] dat_o,
   output var  logic        ack_o,
   // timer inputs
   input  wire logic        on_trg_i,
   input  wire logic        off_trg_i,
   input  wire logic        off_clr_i,
   input  wire logic        pwr_restore_i,
   input  wire logic [31:0] on_ext_val_i,
   input  wire logic [31:0] off_ext_val_i,
   // timer outputs
   output var  logic        on_q_o,
   output var  logic        off_q_o,
   output var  logic [31:0] on_elapsed_o,
   output var  logic [31:0] off_elapsed_o
);
   import oodt_pkg::*;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      // bus side
      logic        ack;
      logic [31:0] dat;
      logic [1:0]  ctrl;
      oodt_cfg_t   on_cfg;
      oodt_cfg_t   off_cfg;
      // timer state
      logic        on_prev;
      logic        on_q;
      logic [31:0] on_el;
      logic        off_prev;
      logic        off_q;
      logic [31:0] off_el;
   } oodt_top_st_t;

   oodt_top_st_t st_r;
   oodt_top_st_t st_nxt;
   logic         tick;

   // delays resolved outside
   oodt_dly_if on_dly ();
   oodt_dly_if off_dly ();

   // ----------------------------------------------------------------------
   // time base and delay resolvers
   // ----------------------------------------------------------------------
   oodt_tick #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .tick_o (tick)
   );

   oodt_delay_cv u_on_cv (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .dly   (on_dly.cvt)
   );

   oodt_delay_cv u_off_cv (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .dly   (off_dly.cvt)
   );

   // settings and cross-referenced elapsed values
   // either may time on the other
   assign on_dly.cfg       = st_r.on_cfg;
   assign on_dly.ext_val   = $signed(on_ext_val_i);
   assign on_dly.peer_val  = st_r.off_el;
   assign off_dly.cfg      = st_r.off_cfg;
   assign off_dly.ext_val  = $signed(off_ext_val_i);
   assign off_dly.peer_val = st_r.on_el;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // byte-lane merge of a write into a register
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
         begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // elapsed step, saturating at the delay
   function automatic logic [31:0] step(input logic [31:0] el,
                                        input logic [31:0] dly);
      // lowered delay clips elapsed
      if (el >= dly)
         return dly;
      else if (dly - el < `OODT_MS_PER_TICK)
         return dly;
      else
         return el + `OODT_MS_PER_TICK;
   endfunction

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   // bus, timers, power return
   always_comb
   begin
      logic        req;
      logic [31:0] rd;
      logic [31:0] wv;
      logic        on_rise;
      logic        off_fall;
      st_nxt   = st_r;
      req      = cyc_i && stb_i && !st_r.ack;
      rd       = 32'h0;
      wv       = 32'h0;
      on_rise  = on_trg_i && !st_r.on_prev;
      off_fall = !off_trg_i && st_r.off_prev;

      // bus: answer one cycle after the request, drop the next
      // held strobe retaken later
      st_nxt.ack = req;
      case (adr_i[7:0])
         `OODT_OFF_CTRL:        rd = {30'h0, st_r.ctrl};
         `OODT_OFF_ON_CFG:      rd = {14'h0, st_r.on_cfg};
         `OODT_OFF_OFF_CFG:     rd = {14'h0, st_r.off_cfg};
         `OODT_OFF_STATUS:      rd = {28'h0, st_r.off_prev, st_r.on_prev,
                                      st_r.off_q, st_r.on_q};
         `OODT_OFF_ON_ELAPSED:  rd = st_r.on_el;
         `OODT_OFF_OFF_ELAPSED: rd = st_r.off_el;
         `OODT_OFF_ON_DELAY:    rd = on_dly.delay_ms;
         `OODT_OFF_OFF_DELAY:   rd = off_dly.delay_ms;
         // unmapped reads give 0
         default:               rd = 32'h0;
      endcase
      // held until next request
      if (req)
      begin
         st_nxt.dat = we_i ? 32'h0 : rd;
      end
      if (req && we_i)
      begin
         case (adr_i[7:0])
            `OODT_OFF_CTRL:
            begin
               wv          = wmerge({30'h0, st_r.ctrl}, dat_i, sel_i);
               st_nxt.ctrl = wv[1:0];
            end
            `OODT_OFF_ON_CFG:
            begin
               wv            = wmerge({14'h0, st_r.on_cfg}, dat_i, sel_i);
               st_nxt.on_cfg = oodt_cfg_t'(wv[`OODT_CFG_WIDTH-1:0]);
            end
            `OODT_OFF_OFF_CFG:
            begin
               wv             = wmerge({14'h0, st_r.off_cfg}, dat_i, sel_i);
               st_nxt.off_cfg = oodt_cfg_t'(wv[`OODT_CFG_WIDTH-1:0]);
            end
            default:
            begin
               // writes dropped
               wv = 32'h0;
            end
         endcase
      end

      // timers, evaluated once per tick
      // gaps between ticks unseen
      if (tick)
      begin
         st_nxt.on_prev  = on_trg_i;
         st_nxt.off_prev = off_trg_i;

         // on-delay
         // low trigger wins
         if (!on_trg_i)
         begin
            st_nxt.on_el = 32'h0;
            st_nxt.on_q  = 1'b0;
         end
         else
         begin
            st_nxt.on_el = on_rise ? 32'h0
                                   : step(st_r.on_el, on_dly.delay_ms);
            st_nxt.on_q  = (st_nxt.on_el >= on_dly.delay_ms);
         end

         // off-delay
         // clear, trigger, count
         if (off_clr_i)
         begin
            st_nxt.off_el = 32'h0;
            st_nxt.off_q  = 1'b0;
         end
         else if (off_trg_i)
         begin
            st_nxt.off_el = 32'h0;
            st_nxt.off_q  = 1'b1;
         end
         else if (st_r.off_q)
         begin
            st_nxt.off_el = off_fall ? 32'h0
                                     : step(st_r.off_el, off_dly.delay_ms);
            st_nxt.off_q  = (st_nxt.off_el < off_dly.delay_ms);
         end
      end

      // power return: kept blocks hold, others take defaults
      // beats a same-cycle tick
      if (pwr_restore_i)
      begin
         if (!st_r.ctrl[`OODT_CTRL_ON_KEEP])
         begin
            st_nxt.on_el   = 32'h0;
            st_nxt.on_q    = 1'b0;
            st_nxt.on_prev = 1'b0;
         end
         if (!st_r.ctrl[`OODT_CTRL_OFF_KEEP])
         begin
            st_nxt.off_el   = 32'h0;
            st_nxt.off_q    = 1'b0;
            st_nxt.off_prev = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   // ce_i low freezes all
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_r         <= '0;
         st_r.ctrl    <= `OODT_CTRL_RST;
         st_r.on_cfg  <= oodt_cfg_t'(`OODT_CFG_RST);
         st_r.off_cfg <= oodt_cfg_t'(`OODT_CFG_RST);
      end
      else if (ce_i)
      begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from state
   // ports fed by flops only
   assign dat_o         = st_r.dat;
   assign ack_o         = st_r.ack;
   assign on_q_o        = st_r.on_q;
   assign off_q_o       = st_r.off_q;
   assign on_elapsed_o  = st_r.on_el;
   assign off_elapsed_o = st_r.off_el;
endmodule

`default_nettype wire
